// File: design/svd_ctrl.sv
// Functional notes
// (RULE1) software writes the 4-bit trip point in bits 3:0 before enabling
// (RULE2) direction 1 detects rise above trip point, 0 detects fall below
// (RULE3) setting detector enable switches the detector on
// (RULE4) software clears flag bit 2 after enabling, stale flag possible
// (RULE5) interrupt needs detector enable bit 2 and global enable bit 7
// (RULE6) no detector interrupt while reference-stable is clear
// (RULE7) software disables detector before changing direction or trip point
// (RULE8) start-up interval counted on clock-independent reference tick
// (RULE9) flag inhibited until start-up elapsed and reference stable
// (RULE10) crossings during start-up need not be latched
// (RULE11) reference switched off means full start-up again
// (RULE12) software may enable detector only for brief check windows
// (RULE13) enabled and stable crossing in chosen direction sets sticky flag
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module svd_ctrl
    import svd_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output var  logic [31:0]       prdata_out,
    output var  logic              pready_out,
    output var  logic              pslverr_out,
    input  wire logic              ref_tick_in,
    input  wire logic              bor_ref_request_in,
    input  wire logic              supply_above_trip_in,
    output var  logic              detector_on_out,
    output var  logic              reference_on_out,
    output var  logic [3:0]        trip_point_select_out,
    output var  logic              direction_select_out,
    output var  logic              irq_out
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [3:0]     trip_point_select;
    logic           direction_select;
    logic           detector_enable;
    logic           detector_flag;
    logic           detector_irq_enable;
    logic           global_irq_enable;
    logic [3:0]     next_trip_point_select;
    logic           next_direction_select;
    logic           next_detector_enable;
    logic           next_detector_flag;
    logic           next_detector_irq_enable;
    logic           next_global_irq_enable;
    logic [31:0]    next_prdata;
    logic           next_pready;
    logic           next_pslverr;
    logic           wr_strobe;
    logic           hit;
    logic           crossing;
    svd_ref_state_t ref_state;
    svd_ref_state_t next_ref_state;
    logic [7:0]     ref_cnt;
    logic [7:0]     next_ref_cnt;
    logic           reference_stable;
    logic           ref_request;
    logic           next_irq;

    assign wr_strobe        = psel_in & penable_in & pready_out & pwrite_in;
    assign reference_stable = (ref_state == SVD_REF_STABLE); // RULE10
    assign ref_request      = detector_enable | bor_ref_request_in; // RULE11
    assign hit = (paddr_in == OFS_CTRL) | (paddr_in == OFS_FLAGS2)
               | (paddr_in == OFS_ENABLES2) | (paddr_in == OFS_IRQ_CTRL);
    // level compare: direction 1 wants above, 0 wants below
    assign crossing = direction_select ? supply_above_trip_in // RULE2
                                       : ~supply_above_trip_in;

    // ----------------------------------------
    // apb slave, one wait-free access phase
    // ----------------------------------------
    always_comb
    begin
        next_pready  = psel_in & ~penable_in;
        next_pslverr = psel_in & ~penable_in & ~hit;
        next_prdata  = RDATA_RST;
        if (psel_in & ~penable_in & ~pwrite_in)
        begin
            case (paddr_in)
                OFS_CTRL:
                begin
                    next_prdata[TRIP_LSB +: TRIP_W] = trip_point_select;
                    next_prdata[DIR_BIT]            = direction_select;
                    next_prdata[STABLE_BIT]         = reference_stable;
                    next_prdata[DET_EN_BIT]         = detector_enable;
                end
                OFS_FLAGS2:   next_prdata[DET_FLAG_BIT] = detector_flag;
                OFS_ENABLES2: next_prdata[DET_IE_BIT]   = detector_irq_enable;
                OFS_IRQ_CTRL: next_prdata[GIE_BIT]      = global_irq_enable;
                default:      next_prdata = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prdata_out  <= RDATA_RST;
            pready_out  <= BIT_RST;
            pslverr_out <= BIT_RST;
        end
        else
        begin
            prdata_out  <= next_prdata;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
        end
    end

    // ----------------------------------------
    // control and flag registers
    // ----------------------------------------
    always_comb
    begin
        next_trip_point_select   = trip_point_select;
        next_direction_select    = direction_select;
        next_detector_enable     = detector_enable;
        next_detector_flag       = detector_flag;
        next_detector_irq_enable = detector_irq_enable;
        next_global_irq_enable   = global_irq_enable;
        if (wr_strobe)
        begin
            case (paddr_in)
                OFS_CTRL:
                begin
                    next_trip_point_select = pwdata_in[TRIP_LSB +: TRIP_W]; // RULE1
                    next_direction_select  = pwdata_in[DIR_BIT]; // RULE2
                    next_detector_enable   = pwdata_in[DET_EN_BIT]; // RULE3
                end
                // writing 0 clears the flag, writing 1 leaves it alone
                OFS_FLAGS2:   next_detector_flag = detector_flag & pwdata_in[DET_FLAG_BIT];
                OFS_ENABLES2: next_detector_irq_enable = pwdata_in[DET_IE_BIT];
                OFS_IRQ_CTRL: next_global_irq_enable   = pwdata_in[GIE_BIT];
                default:      next_detector_flag = detector_flag;
            endcase
        end
        // set after the clear so a same-cycle event is kept
        if (detector_enable & reference_stable & crossing) // RULE9
            next_detector_flag = 1'b1; // RULE13
        next_irq = detector_flag & reference_stable // RULE6
                 & detector_irq_enable & global_irq_enable; // RULE5
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            trip_point_select   <= TRIP_RST;
            direction_select    <= BIT_RST;
            detector_enable     <= BIT_RST;
            detector_flag       <= BIT_RST;
            detector_irq_enable <= BIT_RST;
            global_irq_enable   <= BIT_RST;
            irq_out             <= BIT_RST;
        end
        else
        begin
            trip_point_select   <= next_trip_point_select;
            direction_select    <= next_direction_select;
            detector_enable     <= next_detector_enable;
            detector_flag       <= next_detector_flag;
            detector_irq_enable <= next_detector_irq_enable;
            global_irq_enable   <= next_global_irq_enable;
            irq_out             <= next_irq;
        end
    end

    // ----------------------------------------
    // reference start-up timer
    // ----------------------------------------
    // counts reference ticks, not system clocks, so the interval
    // stays fixed whatever the system clock rate
    always_comb
    begin
        next_ref_state = ref_state;
        next_ref_cnt   = ref_cnt;
        case (ref_state)
            SVD_REF_OFF:
            begin
                next_ref_cnt = REF_CNT_ZERO;
                if (ref_request)
                    next_ref_state = SVD_REF_STARTING;
            end
            SVD_REF_STARTING:
            begin
                if (!ref_request) // RULE11
                begin
                    next_ref_state = SVD_REF_OFF;
                    next_ref_cnt   = REF_CNT_ZERO;
                end
                else if (ref_tick_in) // RULE8
                begin
                    next_ref_cnt = ref_cnt + REF_CNT_ONE;
                    if (ref_cnt == REF_CNT_W'(REF_STARTUP_TICKS - 1))
                        next_ref_state = SVD_REF_STABLE;
                end
            end
            SVD_REF_STABLE:
            begin
                if (!ref_request) // RULE11
                    next_ref_state = SVD_REF_OFF;
            end
            default: next_ref_state = SVD_REF_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ref_state             <= SVD_REF_OFF;
            ref_cnt               <= REF_CNT_ZERO;
            detector_on_out       <= BIT_RST;
            reference_on_out      <= BIT_RST;
            trip_point_select_out <= TRIP_RST;
            direction_select_out  <= BIT_RST;
        end
        else
        begin
            ref_state             <= next_ref_state;
            ref_cnt               <= next_ref_cnt;
            detector_on_out       <= next_detector_enable; // RULE3
            reference_on_out      <= next_ref_state != SVD_REF_OFF;
            trip_point_select_out <= next_trip_point_select;
            direction_select_out  <= next_direction_select;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_irq_needs_both;
        irq_out |-> $past(detector_irq_enable) && $past(global_irq_enable);
    endproperty
    a_irq_needs_both: assert property (p_irq_needs_both) // RULE5
        else $error("irq without both enables");

    property p_irq_needs_stable;
        irq_out |-> $past(reference_stable);
    endproperty
    a_irq_needs_stable: assert property (p_irq_needs_stable) // RULE6
        else $error("irq before reference stable");

    property p_flag_inhibited;
        (!detector_flag && !reference_stable) |=> !detector_flag;
    endproperty
    a_flag_inhibited: assert property (p_flag_inhibited) // RULE9
        else $error("flag set while reference unstable");

    property p_flag_sets;
        (detector_enable && reference_stable && crossing) |=> detector_flag;
    endproperty
    a_flag_sets: assert property (p_flag_sets) // RULE13
        else $error("crossing did not set flag");

    property p_dir_rise;
        (detector_enable && reference_stable && direction_select
         && !supply_above_trip_in && !detector_flag && !wr_strobe) |=> !detector_flag;
    endproperty
    a_dir_rise: assert property (p_dir_rise) // RULE2
        else $error("rise mode flagged below trip point");

    property p_ref_restart;
        !ref_request |=> ref_state == SVD_REF_OFF ##1 !reference_stable;
    endproperty
    a_ref_restart: assert property (p_ref_restart) // RULE11
        else $error("reference stayed stable after switch off");

    property p_ref_ticks;
        (ref_state == SVD_REF_STARTING && !ref_tick_in) |=> ref_cnt == $past(ref_cnt)
                                                         || ref_state == SVD_REF_OFF;
    endproperty
    a_ref_ticks: assert property (p_ref_ticks) // RULE8
        else $error("start-up count moved without reference tick");

    property p_stable_after_count;
        $rose(reference_stable) |-> $past(ref_cnt) == REF_CNT_W'(REF_STARTUP_TICKS - 1);
    endproperty
    a_stable_after_count: assert property (p_stable_after_count) // RULE9
        else $error("reference stable before full interval");

    property p_enable_drives;
        (wr_strobe && paddr_in == OFS_CTRL) |=> detector_on_out == $past(pwdata_in[DET_EN_BIT]);
    endproperty
    a_enable_drives: assert property (p_enable_drives) // RULE3
        else $error("detector power not following enable write");
endmodule : svd_ctrl
`default_nettype wire

// File: design/svd_pkg.sv
// ----------------------------------------
// supply voltage detector constants
// ----------------------------------------
package svd_pkg;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned TRIP_W        = 4;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_FLAGS2    = 12'h004;
    localparam logic [11:0] OFS_ENABLES2  = 12'h008;
    localparam logic [11:0] OFS_IRQ_CTRL  = 12'h00c;
    // control register fields
    localparam int unsigned TRIP_LSB      = 0;
    localparam int unsigned DIR_BIT       = 4;
    localparam int unsigned STABLE_BIT    = 6;
    localparam int unsigned DET_EN_BIT    = 7;
    // flag and enable registers
    localparam int unsigned DET_FLAG_BIT  = 2;
    localparam int unsigned DET_IE_BIT    = 2;
    localparam int unsigned GIE_BIT       = 7;
    // reset values
    localparam logic [3:0]  TRIP_RST      = 4'h0;
    localparam logic        BIT_RST       = 1'b0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
    // reference start-up, timed on the independent reference tick
    localparam int unsigned REF_STARTUP_US = 20;
    localparam int unsigned REF_TICK_US    = 1;
    localparam int unsigned REF_STARTUP_TICKS =
        (REF_STARTUP_US + REF_TICK_US - 1) / REF_TICK_US;
    localparam int unsigned REF_CNT_W     = 8;
    localparam logic [7:0]  REF_CNT_ZERO  = 8'h00;
    localparam logic [7:0]  REF_CNT_ONE   = 8'h01;
    typedef enum logic [1:0] {
        SVD_REF_OFF,
        SVD_REF_STARTING,
        SVD_REF_STABLE
    } svd_ref_state_t;
endpackage : svd_pkg

// File: sim/svd_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module svd_analog_model #(
    parameter int TICK_CYC = 12
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       detector_on_in,
    input  wire logic [3:0] trip_point_select_in,
    input  wire logic [4:0] supply_level_in,
    output var  logic       ref_tick_out,
    output var  logic       supply_above_trip_out
);
    int   tick_cnt;
    logic junk;
    // ----------------------------------------
    // reference timebase
    // ----------------------------------------
    // free running, so start-up is not a count of bus cycles
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tick_cnt     <= 0;
            ref_tick_out <= 1'b0;
            junk         <= 1'b0;
        end
        else
        begin
            tick_cnt     <= (tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
            ref_tick_out <= (tick_cnt == TICK_CYC - 1);
            junk         <= ~junk;
        end
    end
    // ----------------------------------------
    // comparator
    // ----------------------------------------
    // unpowered comparator output is meaningless, so it wanders
    assign supply_above_trip_out = detector_on_in ?
        (supply_level_in > {1'b0, trip_point_select_in}) : junk;
endmodule : svd_analog_model
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import svd_pkg::*;
    logic        sys_clk_in;
    logic        rst_b_in;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tick;
    logic        bor;
    logic        above;
    logic        det_on;
    logic        ref_on;
    logic [3:0]  trip;
    logic        dir;
    logic        irq;
    logic [4:0]  level;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          total_checks;

    svd_ctrl svd_ctrl_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ref_tick_in(tick), .bor_ref_request_in(bor), .supply_above_trip_in(above),
        .detector_on_out(det_on), .reference_on_out(ref_on),
        .trip_point_select_out(trip), .direction_select_out(dir), .irq_out(irq));
    svd_analog_model svd_analog_model_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .detector_on_in(det_on), .trip_point_select_in(trip), .supply_level_in(level),
        .ref_tick_out(tick), .supply_above_trip_out(above));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic finish_test();
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ----------------------------------------
    // bus master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        bit got;
        got = 0;
        @(posedge sys_clk_in);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        pen <= 1'b1;
        for (int i = 0; i < 16 && !got; i++)
        begin
            // design flops update after this, so these are the values at the edge
            @(posedge sys_clk_in);
            if (pready === 1'b1)
            begin
                got = 1;
                rd  = prdata;
                er  = pslverr;
            end
        end
        // request released only at the edge that samples pready
        psel <= 1'b0;
        pen  <= 1'b0;
        // let that edge's flops settle before the caller looks at outputs
        @(negedge sys_clk_in);
        if (!got)
        begin
            err_total++;
            finish_test();
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic ticks(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 100 * n && seen < n; i++)
        begin
            @(negedge sys_clk_in);
            if (tick === 1'b1)
                seen++;
        end
        if (seen < n)
        begin
            err_total++;
            finish_test();
        end
    endtask : ticks

    task automatic irq_chk(input logic exp);
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_chk

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({26'h0, det_on, ref_on, trip}, 32'h0);
        rdchk(OFS_CTRL, 32'h0);
        rdchk(OFS_FLAGS2, 32'h0);
        rdchk(OFS_ENABLES2, 32'h0);
        rdchk(OFS_IRQ_CTRL, 32'h0);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1);
        rdchk(12'h010, 32'h0);
        chk({31'h0, er}, 32'h1);
        rdchk(OFS_CTRL, 32'h0);
    endtask : t_reset

    task automatic t_rise();
        apb(1'b1, OFS_CTRL, 32'h0000_001a);
        chk({27'h0, det_on, dir, trip}, 32'h0000_001a);
        @(posedge sys_clk_in);
        level <= 5'h1f;
        apb(1'b1, OFS_CTRL, 32'h0000_009a);
        chk({31'h0, det_on}, 32'h1);
        // reference power follows the registered enable one edge later
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({31'h0, ref_on}, 32'h1);
        apb(1'b1, OFS_FLAGS2, 32'h0);
        ticks(18);
        rdchk(OFS_CTRL, 32'h0000_009a);
        rdchk(OFS_FLAGS2, 32'h0);
        ticks(3);
        rdchk(OFS_CTRL, 32'h0000_00da);
        rdchk(OFS_FLAGS2, 32'h4);
        apb(1'b1, OFS_ENABLES2, 32'h4);
        irq_chk(1'b0);
        apb(1'b1, OFS_IRQ_CTRL, 32'h80);
        irq_chk(1'b1);
        @(posedge sys_clk_in);
        level <= 5'h00;
        apb(1'b1, OFS_FLAGS2, 32'h0);
        rdchk(OFS_FLAGS2, 32'h0);
        irq_chk(1'b0);
    endtask : t_rise

    task automatic t_fall();
        apb(1'b1, OFS_CTRL, 32'h0000_001a);
        chk({31'h0, det_on}, 32'h0);
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({31'h0, ref_on}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        apb(1'b1, OFS_CTRL, 32'h0000_0085);
        ticks(18);
        rdchk(OFS_CTRL, 32'h0000_0085);
        rdchk(OFS_FLAGS2, 32'h0);
        irq_chk(1'b0);
        // two spare ticks: the flag only sets one edge after the reference turns stable
        ticks(4);
        rdchk(OFS_FLAGS2, 32'h4);
        irq_chk(1'b1);
        apb(1'b1, OFS_IRQ_CTRL, 32'h0);
        irq_chk(1'b0);
    endtask : t_fall

    task automatic t_bor();
        @(posedge sys_clk_in);
        bor <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        chk({30'h0, det_on, ref_on}, 32'h1);
        rdchk(OFS_CTRL, 32'h0000_0045);
        apb(1'b1, OFS_CTRL, 32'h0000_0085);
        rdchk(OFS_CTRL, 32'h0000_00c5);
        @(posedge sys_clk_in);
        bor <= 1'b0;
    endtask : t_bor

    initial
    begin
        err_total    = 0;
        total_checks = 0;
        rst_b_in     = 1'b0;
        {psel, pen, pwr, bor} = 4'h0;
        paddr  = 12'h0;
        pwdata = 32'h0;
        level  = 5'h00;
        rd     = 32'h0;
        er     = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_rise();
        t_fall();
        t_bor();
        finish_test();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge sys_clk_in);
        err_total++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
